// ==== verilog/brf_cfg.svh ====
`ifndef BRF_CFG_SVH
`define BRF_CFG_SVH

// ==========================================
// Sizes
`define BRF_DEPTH 16
`define BRF_PTR_W 4
`define BRF_ADDR_W 8
`define BRF_DATA_W 64
`define BRF_VA_W 48
`define BRF_VA_MSB 47
`define BRF_SEL_W 10
`define BRF_LP_COUNT 2
`define BRF_LP_W 1
`define BRF_RING_W 2

// ==========================================
// Select bit positions
`define BRF_SEL_RING0 0
`define BRF_SEL_RINGNZ 1
`define BRF_SEL_COND 2
`define BRF_SEL_RELCALL 3
`define BRF_SEL_INDCALL 4
`define BRF_SEL_RET 5
`define BRF_SEL_INDJMP 6
`define BRF_SEL_RELJMP 7
`define BRF_SEL_FAR 8
`define BRF_SEL_CALLSTACK 9
`define BRF_SEL_RESET 10'h000

// ==========================================
// Record layout
`define BRF_SRC_SEXT_W 13
`define BRF_DST_SEXT_W 16
`define BRF_SRC_ABORT 61
`define BRF_SRC_INTX 62
`define BRF_SRC_MISP 63
`define BRF_DBG_REC 0

// ==========================================
// Register map
`define BRF_OFF_SEL0 8'h00
`define BRF_OFF_DBGCTL 8'h02
`define BRF_OFF_TOS 8'h03
`define BRF_PAGE_SRC 4'h1
`define BRF_PAGE_DST 4'h2
`define BRF_RING_ZERO 2'h0
`define BRF_ZERO64 64'h0000000000000000

`endif

// ==== verilog/brf_pkg.sv ====
`include "brf_cfg.svh"

package brf_pkg;

  // ==========================================
  // Branch kinds, encoded as their select bit
  typedef enum logic [3:0] {
    BRF_K_COND = 4'(`BRF_SEL_COND),
    BRF_K_RELCALL = 4'(`BRF_SEL_RELCALL),
    BRF_K_INDCALL = 4'(`BRF_SEL_INDCALL),
    BRF_K_RET = 4'(`BRF_SEL_RET),
    BRF_K_INDJMP = 4'(`BRF_SEL_INDJMP),
    BRF_K_RELJMP = 4'(`BRF_SEL_RELJMP),
    BRF_K_FAR = 4'(`BRF_SEL_FAR)
  } brf_kind_e;

  // ==========================================
  // One retired transfer from the core
  typedef struct packed {
    logic valid;
    logic [`BRF_LP_W-1:0] lp;
    brf_kind_e kind;
    logic [`BRF_RING_W-1:0] ring;
    logic zero_len;
    logic mispredict_flag;
    logic abort;
    logic in_tx;
    logic [`BRF_VA_W-1:0] src;
    logic [`BRF_VA_W-1:0] dst;
  } brf_branch_s;

  typedef logic [`BRF_SEL_W-1:0] brf_sel_t;

endpackage

// ==== verilog/brf_sel_reg.sv ====
`timescale 1ns/10ps
`include "brf_cfg.svh"

module brf_sel_reg (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wr_i,
  input wire logic [`BRF_SEL_W-1:0] wdata_i,
  output brf_pkg::brf_sel_t sel_o
);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_o <= `BRF_SEL_RESET;
    end else if (wr_i) begin
      sel_o <= wdata_i;
    end
  end

endmodule

// ==== verilog/brf_filter.sv ====
`timescale 1ns/10ps
`include "brf_cfg.svh"

module brf_filter (
  input wire brf_pkg::brf_sel_t sel_i,
  input wire brf_pkg::brf_branch_s br_i,
  output logic keep_o,
  output logic pop_o
);

  wire logic ring_zero;
  wire logic ring_hit;
  wire logic type_hit;
  wire logic cs_mode;
  wire logic is_ret;
  wire logic is_call;
  wire logic zlen_drop;

  assign ring_zero = (br_i.ring == `BRF_RING_ZERO);
  // Ring suppression applies to every kind, returns included
  assign ring_hit = ring_zero ? sel_i[`BRF_SEL_RING0]
                              : sel_i[`BRF_SEL_RINGNZ];
  // Kind code is the select bit, so jumps never alias calls
  assign type_hit = sel_i[br_i.kind];
  // Jump bits cover jumps only; calls and returns use their own
  assign cs_mode = sel_i[`BRF_SEL_CALLSTACK];
  assign is_ret = (br_i.kind == brf_pkg::BRF_K_RET);
  assign is_call = (br_i.kind == brf_pkg::BRF_K_RELCALL) ||
                   (br_i.kind == brf_pkg::BRF_K_INDCALL);
  assign zlen_drop = cs_mode && is_call && br_i.zero_len;

  // Plain ring mode when cs_mode is low
  assign keep_o = br_i.valid && !ring_hit && !type_hit &&
                  !(cs_mode && is_ret) && !zlen_drop;
  assign pop_o = br_i.valid && cs_mode && is_ret && !ring_hit;

endmodule

// ==== verilog/brf_top.sv ====
`timescale 1ns/10ps
`include "brf_cfg.svh"

// Overview of operation
// - Each logical processor owns a separate branch filter select register.
// - Select bit 0 drops branches ending in ring 0.
// - Select bit 1 drops branches ending in a ring above 0.
// - Select bit 2 drops conditional branches.
// - Select bit 3 drops near relative calls.
// - Select bit 4 drops near indirect calls.
// - Select bit 5 drops near returns.
// - Select bit 6 drops indirect jumps only, not indirect calls or returns.
// - Select bit 7 drops relative jumps only, not relative calls.
// - Select bit 8 drops far branches.
// - Select bit 9 turns on last-in first-out call-stack filtering.
// - With bit 9 clear, records form a plain ring, filtered by suppress bits.
// - Call-stack mode records calls; each return not dropped by its ring bit removes the newest pair.
// - Call-stack mode never records zero-length calls.
// - Recording runs only while debug control bit 0 is set.
// - Sixteen source and destination record pairs form the stack.
// - Top pointer names the newest pair, steps modulo 16 before writing.
// - Source record holds address 47:0, sign copies of bit 47 in 60:48.
// - Source bit 61 marks abort entries, bit 62 in-transaction entries.
// - Source bit 63 marks mispredicted target or direction.
// - Destination record holds address 47:0, sign copies in 63:48.
// - Select registers clear to zero at reset, suppressing nothing.
module brf_top (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [`BRF_ADDR_W-1:0] ADDR_I,
  input wire logic [`BRF_DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [`BRF_DATA_W-1:0] RDATA_O,
  input wire brf_pkg::brf_branch_s BRANCH_I,
  output logic [`BRF_PTR_W-1:0] TOS_O
);

  // ==========================================
  // Address decode
  wire logic [`BRF_PTR_W-1:0] a_page;
  wire logic [`BRF_PTR_W-1:0] a_idx;
  wire logic hit_dbg;
  wire logic hit_tos;
  wire logic hit_src;
  wire logic hit_dst;
  wire logic [`BRF_LP_COUNT-1:0] hit_sel;

  assign a_page = ADDR_I[`BRF_ADDR_W-1:`BRF_PTR_W];
  assign a_idx = ADDR_I[`BRF_PTR_W-1:0];
  assign hit_dbg = (ADDR_I == `BRF_OFF_DBGCTL);
  assign hit_tos = (ADDR_I == `BRF_OFF_TOS);
  assign hit_src = (a_page == `BRF_PAGE_SRC);
  assign hit_dst = (a_page == `BRF_PAGE_DST);

  // ==========================================
  // Per-processor select registers
  brf_pkg::brf_sel_t sel_vec [`BRF_LP_COUNT];

  genvar g;
  generate
    for (g = 0; g < `BRF_LP_COUNT; g = g + 1) begin : g_lp
      assign hit_sel[g] = (ADDR_I == (`BRF_OFF_SEL0 + `BRF_ADDR_W'(g)));
      // Reserved bits are not stored and read back as zero
      brf_sel_reg u_sel (
        .clk_i(SYS_CLK_I),
        .rstn_i(RSTN_I),
        .wr_i(WR_I && hit_sel[g]),
        .wdata_i(WDATA_I[`BRF_SEL_W-1:0]),
        .sel_o(sel_vec[g])
      );
    end
  endgenerate

  // Transfer uses the select register of its own processor
  brf_pkg::brf_sel_t sel_cur;
  assign sel_cur = sel_vec[BRANCH_I.lp];

  // ==========================================
  // Filter
  logic keep;
  logic pop_req;

  brf_filter u_filter (
    .sel_i(sel_cur),
    .br_i(BRANCH_I),
    .keep_o(keep),
    .pop_o(pop_req)
  );

  // ==========================================
  // Debug control and pointer
  logic rec_en;
  logic [`BRF_PTR_W-1:0] top_of_stack_pointer;
  wire logic hw_push;
  wire logic hw_pop;
  wire logic sw_tos_wr;
  wire logic [`BRF_PTR_W-1:0] tos_inc;
  wire logic [`BRF_PTR_W-1:0] tos_dec;
  wire logic [`BRF_PTR_W-1:0] next_tos;

  assign hw_push = rec_en && keep;
  assign hw_pop = rec_en && pop_req;
  assign sw_tos_wr = WR_I && hit_tos;
  // Width of the pointer gives the modulo 16 wrap
  assign tos_inc = top_of_stack_pointer + `BRF_PTR_W'(1);
  assign tos_dec = top_of_stack_pointer - `BRF_PTR_W'(1);
  // Core update beats a software pointer write in the same cycle
  assign next_tos = hw_push ? tos_inc :
                    hw_pop ? tos_dec :
                    sw_tos_wr ? WDATA_I[`BRF_PTR_W-1:0] : top_of_stack_pointer;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rec_en <= 1'b0;
    end else if (WR_I && hit_dbg) begin
      rec_en <= WDATA_I[`BRF_DBG_REC];
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      top_of_stack_pointer <= '0;
    end else begin
      top_of_stack_pointer <= next_tos;
    end
  end

  assign TOS_O = top_of_stack_pointer;

  // ==========================================
  // Record formatting
  wire logic [`BRF_DATA_W-1:0] src_word;
  wire logic [`BRF_DATA_W-1:0] dst_word;

  assign src_word = {BRANCH_I.mispredict_flag,
                     BRANCH_I.in_tx, BRANCH_I.abort,
                     {`BRF_SRC_SEXT_W{BRANCH_I.src[`BRF_VA_MSB]}},
                     BRANCH_I.src};
  assign dst_word = {{`BRF_DST_SEXT_W{BRANCH_I.dst[`BRF_VA_MSB]}},
                     BRANCH_I.dst};

  // ==========================================
  // Record stack
  logic [`BRF_DATA_W-1:0] src_mem [`BRF_DEPTH];
  logic [`BRF_DATA_W-1:0] dst_mem [`BRF_DEPTH];
  wire logic hw_wr;
  wire logic [`BRF_PTR_W-1:0] hw_idx;
  wire logic [`BRF_DATA_W-1:0] hw_src;
  wire logic [`BRF_DATA_W-1:0] hw_dst;
  wire logic sw_src_wr;
  wire logic sw_dst_wr;

  // Popped pair is cleared so stale frames never reappear
  assign hw_wr = hw_push || hw_pop;
  assign hw_idx = hw_push ? tos_inc : top_of_stack_pointer;
  assign hw_src = hw_push ? src_word : `BRF_ZERO64;
  assign hw_dst = hw_push ? dst_word : `BRF_ZERO64;
  // One write port per array; core wins over software
  assign sw_src_wr = WR_I && hit_src && !hw_wr;
  assign sw_dst_wr = WR_I && hit_dst && !hw_wr;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < `BRF_DEPTH; i++) begin
        src_mem[i] <= '0;
        dst_mem[i] <= '0;
      end
    end else if (hw_wr) begin
      src_mem[hw_idx] <= hw_src;
      dst_mem[hw_idx] <= hw_dst;
    end else begin
      if (sw_src_wr) begin
        src_mem[a_idx] <= WDATA_I;
      end
      if (sw_dst_wr) begin
        dst_mem[a_idx] <= WDATA_I;
      end
    end
  end

  // ==========================================
  // Read path
  wire logic [`BRF_DATA_W-1:0] rd_word;
  wire logic [`BRF_DATA_W-1:0] sel_word;
  wire logic any_sel;
  wire logic [`BRF_LP_W-1:0] sel_idx;

  assign any_sel = |hit_sel;
  assign sel_idx = a_idx[`BRF_LP_W-1:0];
  assign sel_word = {{(`BRF_DATA_W-`BRF_SEL_W){1'b0}}, sel_vec[sel_idx]};
  // Unmapped addresses read as zero
  assign rd_word = any_sel ? sel_word :
                   hit_dbg ? {{(`BRF_DATA_W-1){1'b0}}, rec_en} :
                   hit_tos ? {{(`BRF_DATA_W-`BRF_PTR_W){1'b0}}, top_of_stack_pointer} :
                   hit_src ? src_mem[a_idx] :
                   hit_dst ? dst_mem[a_idx] : `BRF_ZERO64;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= '0;
    end else begin
      RDATA_O <= RD_I ? rd_word : `BRF_ZERO64;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  wire logic br_on;
  wire logic quiet;
  wire logic cs_on;
  assign br_on = BRANCH_I.valid && rec_en;
  assign quiet = !sw_tos_wr;
  assign cs_on = sel_cur[`BRF_SEL_CALLSTACK];

  sequence s_ring0_drop;
    br_on && quiet && sel_cur[`BRF_SEL_RING0] && BRANCH_I.ring == `BRF_RING_ZERO;
  endsequence

  sequence s_push;
    hw_push && !sw_tos_wr;
  endsequence

  sequence s_sel0_wr;
    WR_I && ADDR_I == `BRF_OFF_SEL0;
  endsequence

  sequence s_sel0_rd;
    RD_I && ADDR_I == `BRF_OFF_SEL0;
  endsequence

  sequence s_cs_ret;
    br_on && quiet && cs_on && BRANCH_I.kind == brf_pkg::BRF_K_RET;
  endsequence

  AST_RING0_DROP: assert property (s_ring0_drop |=> $stable(top_of_stack_pointer))
    else $error("ring 0 branch changed the pointer");

  AST_RING_NZ_DROP: assert property (
    br_on && quiet && sel_cur[`BRF_SEL_RINGNZ] && BRANCH_I.ring != `BRF_RING_ZERO
    |=> top_of_stack_pointer == $past(top_of_stack_pointer))
    else $error("outer ring branch changed the pointer");

  AST_COND_DROP: assert property (
    br_on && quiet && sel_cur[`BRF_SEL_COND] && BRANCH_I.kind == brf_pkg::BRF_K_COND
    |=> $stable(top_of_stack_pointer))
    else $error("conditional branch recorded while suppressed");

  AST_IND_JMP_KEEPS_CALL: assert property (
    br_on && sel_cur == brf_pkg::brf_sel_t'(1 << `BRF_SEL_INDJMP)
    && BRANCH_I.kind == brf_pkg::BRF_K_INDCALL
    |=> top_of_stack_pointer == $past(top_of_stack_pointer) + `BRF_PTR_W'(1))
    else $error("indirect call lost under jump suppression");

  AST_PUSH_WRITE: assert property (s_push |=>
    top_of_stack_pointer == $past(tos_inc) && src_mem[top_of_stack_pointer] == $past(src_word)
    && dst_mem[top_of_stack_pointer] == $past(dst_word))
    else $error("record not written at next pointer");

  AST_SRC_LAYOUT: assert property (hw_push |->
    src_word[`BRF_SRC_MISP] == BRANCH_I.mispredict_flag
    && src_word[`BRF_SRC_ABORT] == BRANCH_I.abort
    && src_word[`BRF_SRC_ABORT-1] == BRANCH_I.src[`BRF_VA_MSB]
    && dst_word[`BRF_DATA_W-1] == BRANCH_I.dst[`BRF_VA_MSB])
    else $error("record layout wrong");

  AST_RET_POPS: assert property (
    br_on && cs_on && BRANCH_I.kind == brf_pkg::BRF_K_RET && !keep && pop_req
    |=> top_of_stack_pointer == $past(top_of_stack_pointer) - `BRF_PTR_W'(1) && src_mem[$past(top_of_stack_pointer)] == `BRF_ZERO64)
    else $error("return did not remove newest pair");

  AST_ZLEN_SKIP: assert property (
    br_on && quiet && cs_on && BRANCH_I.zero_len
    && BRANCH_I.kind == brf_pkg::BRF_K_RELCALL |=> $stable(top_of_stack_pointer))
    else $error("zero-length call recorded");

  AST_REC_OFF: assert property (
    !rec_en && !sw_tos_wr |=> $stable(top_of_stack_pointer))
    else $error("recorded while recording disabled");

  AST_SEL_READBACK: assert property (
    s_sel0_wr ##1 (s_sel0_rd and !WR_I)
    |=> RDATA_O[`BRF_SEL_W-1:0] == $past(WDATA_I[`BRF_SEL_W-1:0], 2)
    && RDATA_O[`BRF_DATA_W-1:`BRF_SEL_W] == '0)
    else $error("select register readback wrong");

  AST_SEL_ISOLATE: assert property (
    s_sel0_wr |=> $stable(sel_vec[1]))
    else $error("select write leaked to other processor");

  AST_RELCALL_DROP: assert property (
    br_on && quiet && sel_cur[`BRF_SEL_RELCALL] && BRANCH_I.kind == brf_pkg::BRF_K_RELCALL
    |=> $stable(top_of_stack_pointer))
    else $error("relative call recorded while suppressed");

  AST_INDCALL_DROP: assert property (
    br_on && quiet && sel_cur[`BRF_SEL_INDCALL] && BRANCH_I.kind == brf_pkg::BRF_K_INDCALL
    |=> $stable(top_of_stack_pointer))
    else $error("indirect call recorded while suppressed");

  // Call-stack mode pops returns whatever bit 5 says, so only plain mode here
  AST_RET_DROP: assert property (
    br_on && quiet && !cs_on && sel_cur[`BRF_SEL_RET] && BRANCH_I.kind == brf_pkg::BRF_K_RET
    |=> $stable(top_of_stack_pointer))
    else $error("return recorded while suppressed");

  AST_IND_JMP_DROP: assert property (
    br_on && quiet && sel_cur[`BRF_SEL_INDJMP] && BRANCH_I.kind == brf_pkg::BRF_K_INDJMP
    |=> $stable(top_of_stack_pointer))
    else $error("indirect jump recorded while suppressed");

  AST_REL_JMP_DROP: assert property (
    br_on && quiet && sel_cur[`BRF_SEL_RELJMP] && BRANCH_I.kind == brf_pkg::BRF_K_RELJMP
    |=> $stable(top_of_stack_pointer))
    else $error("relative jump recorded while suppressed");

  AST_REL_JMP_KEEPS_CALL: assert property (
    br_on && sel_cur == brf_pkg::brf_sel_t'(1 << `BRF_SEL_RELJMP)
    && BRANCH_I.kind == brf_pkg::BRF_K_RELCALL
    |=> top_of_stack_pointer == $past(top_of_stack_pointer) + `BRF_PTR_W'(1))
    else $error("relative call lost under jump suppression");

  AST_FAR_DROP: assert property (
    br_on && quiet && sel_cur[`BRF_SEL_FAR] && BRANCH_I.kind == brf_pkg::BRF_K_FAR
    |=> $stable(top_of_stack_pointer))
    else $error("far branch recorded while suppressed");

  AST_PLAIN_RING: assert property (
    br_on && sel_cur == `BRF_SEL_RESET
    |=> top_of_stack_pointer == $past(top_of_stack_pointer) + `BRF_PTR_W'(1))
    else $error("unfiltered branch not recorded");

  AST_SEL_RESET: assert property (
    $rose(RSTN_I) |-> sel_vec[0] == `BRF_SEL_RESET
    && sel_vec[1] == `BRF_SEL_RESET)
    else $error("select register not clear after reset");

  AST_TX_FLAGS: assert property (s_push |=>
    src_mem[top_of_stack_pointer][`BRF_SRC_INTX] == $past(BRANCH_I.in_tx)
    && src_mem[top_of_stack_pointer][`BRF_SRC_ABORT] == $past(BRANCH_I.abort))
    else $error("transaction flags not stored");

  AST_DST_LAYOUT: assert property (s_push |=>
    dst_mem[top_of_stack_pointer] == {{`BRF_DST_SEXT_W{$past(BRANCH_I.dst[`BRF_VA_MSB])}}, $past(BRANCH_I.dst)})
    else $error("target record layout wrong");

  AST_CS_RET_NOT_STORED: assert property (s_cs_ret |=>
    top_of_stack_pointer != $past(top_of_stack_pointer) + `BRF_PTR_W'(1))
    else $error("return stored in call-stack mode");

endmodule

// ==== verification/brf_core_model.sv ====
`timescale 1ns/10ps

module brf_core_model (
  input wire logic clk_i,
  output brf_pkg::brf_branch_s br_o
);
  // ==========================================
  // Retire one transfer per call
  initial br_o = '0;

  task automatic send(input brf_pkg::brf_kind_e k, input logic lp, input logic [1:0] rg,
      input logic zl, input logic [2:0] fl, input logic [47:0] s, input logic [47:0] d);
    @(posedge clk_i);
    br_o <= '{valid: 1'b1, lp: lp, kind: k, ring: rg, zero_len: zl, mispredict_flag: fl[2],
      in_tx: fl[1], abort: fl[0], src: s, dst: d};
    @(posedge clk_i);
    // Idle fields other than kind inverted, so stale values never pass for data
    br_o <= '{valid: 1'b0, lp: ~lp, kind: k, ring: ~rg, zero_len: ~zl, mispredict_flag: ~fl[2],
      in_tx: ~fl[1], abort: ~fl[0], src: ~s, dst: ~d};
  endtask
endmodule

// ==== verification/brf_top_bench.sv ====
`timescale 1ns/10ps

module brf_top_bench;
  localparam brf_pkg::brf_kind_e k_rcall = brf_pkg::BRF_K_RELCALL;
  localparam brf_pkg::brf_kind_e k_icall = brf_pkg::BRF_K_INDCALL;
  localparam brf_pkg::brf_kind_e k_ret = brf_pkg::BRF_K_RET;
  localparam brf_pkg::brf_kind_e k_rjmp = brf_pkg::BRF_K_RELJMP;
  localparam brf_pkg::brf_kind_e k_ijmp = brf_pkg::BRF_K_INDJMP;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [63:0] wdata = 64'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [63:0] rdata;
  logic [3:0] top_of_stack_pointer;
  logic [3:0] exp_tos = 4'h0;
  brf_pkg::brf_branch_s br;
  int n_mismatch = 0;
  int compares = 0;
  brf_pkg::brf_kind_e kinds [7] = '{brf_pkg::BRF_K_COND, k_rcall, k_icall, k_ret, k_ijmp,
    k_rjmp, brf_pkg::BRF_K_FAR};

  always #50 clk = ~clk;

  brf_top dut (
    .SYS_CLK_I(clk),
    .RSTN_I(rstn),
    .ADDR_I(addr),
    .WDATA_I(wdata),
    .WR_I(wr),
    .RD_I(rd),
    .RDATA_O(rdata),
    .BRANCH_I(br),
    .TOS_O(top_of_stack_pointer)
  );

  brf_core_model core (
    .clk_i(clk),
    .br_o(br)
  );

  // ==========================================
  // Checking and bus tasks
  task automatic stop_test;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [63:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Write, then read back in the very next cycle
  task automatic wrchk(input logic [7:0] a, input logic [63:0] d, input logic [63:0] exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Send a transfer, then check the pointer moved by dt
  task automatic sb(input brf_pkg::brf_kind_e k, input logic lp, input logic [1:0] rg,
      input logic zl, input int dt, input logic [2:0] fl = 3'h0,
      input logic [47:0] s = 48'h0000_0040_1000);
    core.send(k, lp, rg, zl, fl, s, ~s);
    #1;
    exp_tos = exp_tos + 4'(dt);
    chk({60'h0, top_of_stack_pointer}, {60'h0, exp_tos});
  endtask

  // ==========================================
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rchk(8'h00, 64'h0);
    rchk(8'h01, 64'h0);
    sb(k_rcall, 1'b0, 2'h3, 1'b0, 0);
    wreg(8'h02, 64'h1);
    rchk(8'h02, 64'h1);
    // Reserved bits written as zero, no call-stack bit while probing storage
    wrchk(8'h00, 64'h1ff, 64'h1ff);
    rchk(8'h01, 64'h0);
    rchk(8'h44, 64'h0);
    // Each kind dropped on one processor, kept on the other
    foreach (kinds[i]) begin
      wreg(8'h00, 64'h1 << kinds[i]);
      sb(kinds[i], 1'b0, 2'h3, 1'b0, 0);
      sb(kinds[i], 1'b1, 2'h3, 1'b0, 1);
    end
    wreg(8'h00, 64'h1);
    sb(k_rjmp, 1'b0, 2'h0, 1'b0, 0);
    sb(k_rjmp, 1'b0, 2'h2, 1'b0, 1);
    wreg(8'h00, 64'h2);
    sb(k_rjmp, 1'b0, 2'h0, 1'b0, 1);
    sb(k_rjmp, 1'b0, 2'h1, 1'b0, 0);
    wreg(8'h00, 64'h40);
    sb(k_icall, 1'b0, 2'h3, 1'b0, 1);
    sb(k_ret, 1'b0, 2'h3, 1'b0, 1);
    wreg(8'h00, 64'h80);
    sb(k_rcall, 1'b0, 2'h3, 1'b0, 1);
    sb(k_rcall, 1'b0, 2'h3, 1'b0, 1, 3'h5, 48'h8000_1234_5678);
    rchk({4'h1, exp_tos}, 64'hbfff_8000_1234_5678);
    rchk({4'h2, exp_tos}, 64'h0000_7fff_edcb_a987);
    sb(k_rcall, 1'b0, 2'h3, 1'b0, 1, 3'h2, 48'h0000_0000_0abc);
    rchk({4'h1, exp_tos}, 64'h4000_0000_0000_0abc);
    rchk({4'h2, exp_tos}, 64'hffff_ffff_ffff_f543);
    // Full turn of the ring, pointer checked at every step
    wreg(8'h00, 64'h0);
    repeat (16) sb(k_rjmp, 1'b0, 2'h3, 1'b0, 1);
    rchk({4'h1, exp_tos}, 64'h0000_0040_1000);
    wreg(8'h03, 64'h5);
    exp_tos = 4'h5;
    rchk(8'h03, 64'h5);
    chk({60'h0, top_of_stack_pointer}, 64'h5);
    // Call-stack mode
    wreg(8'h00, 64'h3c4);
    sb(k_rcall, 1'b0, 2'h3, 1'b0, 1, 3'h0, 48'h0000_0000_a000);
    sb(k_icall, 1'b0, 2'h3, 1'b0, 1);
    sb(k_icall, 1'b0, 2'h3, 1'b1, 0);
    sb(brf_pkg::BRF_K_COND, 1'b0, 2'h3, 1'b0, 0);
    sb(k_ret, 1'b0, 2'h3, 1'b0, -1);
    rchk({4'h1, exp_tos + 4'h1}, 64'h0);
    rchk({4'h1, exp_tos}, 64'h0000_0000_0000_a000);
    sb(k_ret, 1'b0, 2'h3, 1'b0, -1);
    sb(k_ret, 1'b1, 2'h3, 1'b0, 1);
    wreg(8'h00, 64'h1c4);
    sb(k_ret, 1'b0, 2'h3, 1'b0, 1);
    wreg(8'h02, 64'h0);
    sb(k_rcall, 1'b0, 2'h3, 1'b0, 0);
    stop_test;
  end
endmodule
